// *** ctm_params.svh ***
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH
// Behaviour
// - Standby low, silent select high and transmit high select normal mode.
// - Normal mode: bus dominant while transmit is low, recessive while high.
// - Normal mode: sampled bus state is presented on the receive output.
// - Active receiver: receive low for dominant bus, high for recessive bus.
// - Normal mode is refused while transmit is low; previous mode is kept.
// - Silent select and standby select both low select silent mode.
// - Silent mode: transmitter off, transmit ignored, bus left recessive.
// - Silent mode: fast comparator runs, receive output keeps following the bus.
// - Standby select high selects standby regardless of the other inputs.
// - Standby: transmitter and fast comparator off, only wake comparator watches.
// - Standby: recessive then dominant beyond filter time drives receive low.
// - A wake-up request alone never leaves standby; standby select must drop.
// - Standby: a dominant time-out returns receive high, no permanent wake request.
// - Undriven mode select inputs read high, so standby is selected.
// - Variant without silent select pin treats that input as always high.
// - Transmit low beyond the dominant time-out is treated high; bus recessive. The code treats it high for the driver only; normal mode is still refused.
// - Undriven transmit input reads high, leaving the bus recessive.

`define CTM_CLK_NS        25
`define CTM_TICK_NS       1000
`define CTM_TICK_CYC      (`CTM_TICK_NS / `CTM_CLK_NS)
`define CTM_TXD_TO_US     3000
`define CTM_DOM_TO_US     3000
`define CTM_WAKE_FILT_US  1

`define CTM_OFS_FILT      8'h00
`define CTM_OFS_STAT      8'h04
`define CTM_FILT_RST      12'h001

`define CTM_STAT_MODE_LSB 0
`define CTM_STAT_WAKE     2
`define CTM_STAT_TXDTO    3
`define CTM_STAT_RXD      4
`define CTM_STAT_DRIVE    5
`endif

// *** ctm_pkg.sv ***
package ctm_pkg;
    typedef enum logic [1:0] {
        CTM_STANDBY,
        CTM_NORMAL,
        CTM_SILENT
    } ctm_mode_t;

    typedef struct packed {
        ctm_mode_t   mode;
        logic [2:0]  standby_select_sy;
        logic [2:0]  sil_sy;
        logic [2:0]  txd_sy;
        logic [2:0]  bus_sy;
        logic [2:0]  wake_sy;
        logic        standby_select_lvl;
        logic        sil_lvl;
        logic        txd_lvl;
        logic        bus_lvl;
        logic        wake_lvl;
        logic [5:0]  tick_cnt;
        logic        tick;
        logic [11:0] txd_cnt;
        logic        txd_to;
        logic        wake_armed;
        logic [11:0] wake_cnt;
        logic        wake_req;
        logic [11:0] dom_cnt;
        logic        rxd;
        logic        drive;
        logic [11:0] filt;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
    } ctm_state_t;
endpackage : ctm_pkg

// *** ctm_top.sv ***
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`include "ctm_params.svh"

module ctm_top #(
    parameter bit          HAS_SILENT   = 1'b1,
    parameter logic [11:0] TXD_TO_TICKS = 12'((`CTM_TXD_TO_US * 1000) / `CTM_TICK_NS),
    parameter logic [11:0] DOM_TO_TICKS = 12'((`CTM_DOM_TO_US * 1000) / `CTM_TICK_NS)
) (
    input  wire logic        hclk,               // 40 MHz system clock
    input  wire logic        hresetn,            // async reset, active low
    input  wire logic        hsel,               // ahb slave select
    input  wire logic [31:0] haddr,              // ahb address
    input  wire logic [1:0]  htrans,             // ahb transfer type
    input  wire logic        hwrite,             // ahb write
    input  wire logic [2:0]  hsize,              // ahb size, word only
    input  wire logic [31:0] hwdata,             // ahb write data
    input  wire logic        hready,             // ahb bus ready
    output logic      [31:0] hrdata,             // ahb read data
    output logic             hreadyout,          // ahb slave ready
    output logic             hresp,              // ahb response, always okay
    input  wire logic        standby_select,     // mode pin, high = standby
    input  wire logic        silent_select_n,    // mode pin, low = silent
    input  wire logic        txd,                // transmit data pin
    input  wire logic        bus_dominant,       // fast bus comparator result
    input  wire logic        wake_dominant,      // wake comparator result
    output logic             rxd,                // receive data pin
    output logic             drive_dominant,     // bus driver dominant
    output logic             transmitter_en,     // bus driver enabled
    output logic             fast_comparator_en, // fast bus comparator on
    output logic             wake_comparator_en  // wake comparator on
);
    ctm_pkg::ctm_state_t st_reg;
    ctm_pkg::ctm_state_t st_next;
    logic                sil_eff;
    logic                addr_ok;

    // three stages; level moves only once stages two and three agree
    function automatic logic [3:0] ctm_sync(input logic [2:0] sy, input logic lvl,
                                            input logic pin);
        logic [2:0] s;
        s = {sy[1:0], pin};
        return {s, (sy[1] == sy[2]) ? sy[2] : lvl};
    endfunction : ctm_sync

    function automatic logic [11:0] ctm_inc(input logic [11:0] v);
        return (v == 12'hFFF) ? v : v + 12'h001;
    endfunction : ctm_inc

    assign sil_eff = HAS_SILENT ? st_reg.sil_lvl : 1'b1;
    assign addr_ok = hsel && hready && htrans[1];

    always_comb begin
        st_next = st_reg;
        {st_next.standby_select_sy, st_next.standby_select_lvl} = ctm_sync(st_reg.standby_select_sy, st_reg.standby_select_lvl,
                                                       standby_select);
        {st_next.sil_sy, st_next.sil_lvl} = ctm_sync(st_reg.sil_sy, st_reg.sil_lvl,
                                                     silent_select_n);
        {st_next.txd_sy, st_next.txd_lvl} = ctm_sync(st_reg.txd_sy, st_reg.txd_lvl, txd);
        {st_next.bus_sy, st_next.bus_lvl} = ctm_sync(st_reg.bus_sy, st_reg.bus_lvl,
                                                     bus_dominant);
        {st_next.wake_sy, st_next.wake_lvl} = ctm_sync(st_reg.wake_sy, st_reg.wake_lvl,
                                                       wake_dominant);

        // free-running time base, one tick per microsecond
        st_next.tick = 1'b0;
        if (st_reg.tick_cnt == 6'(`CTM_TICK_CYC - 1)) begin
            st_next.tick_cnt = 6'h00;
            st_next.tick     = 1'b1;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt + 6'h01;
        end

        // stuck-low transmit input is overridden after the time-out
        if (st_reg.txd_lvl) begin
            st_next.txd_cnt = 12'h000;
            st_next.txd_to  = 1'b0;
        end else if (st_reg.tick) begin
            st_next.txd_cnt = ctm_inc(st_reg.txd_cnt);
            if (st_reg.txd_cnt >= TXD_TO_TICKS) begin
                st_next.txd_to = 1'b1;
            end
        end

        if (st_reg.standby_select_lvl) begin
            st_next.mode = ctm_pkg::CTM_STANDBY;
        end else if (!sil_eff) begin
            st_next.mode = ctm_pkg::CTM_SILENT;
        end else if (st_reg.txd_lvl) begin
            st_next.mode = ctm_pkg::CTM_NORMAL;
        end else begin
            st_next.mode = st_reg.mode;
        end

        if (st_next.mode == ctm_pkg::CTM_STANDBY) begin
            // arming needs a recessive bus first, so a bus already dominant
            // on entry never wakes by itself
            if (!st_reg.wake_lvl) begin
                st_next.wake_armed = 1'b1;
                st_next.wake_cnt   = 12'h000;
                st_next.dom_cnt    = 12'h000;
            end else if (st_reg.wake_armed && st_reg.tick) begin
                st_next.wake_cnt = ctm_inc(st_reg.wake_cnt);
                if (st_reg.wake_cnt >= st_reg.filt) begin
                    st_next.wake_req = 1'b1;
                end
                if (st_reg.wake_req) begin
                    st_next.dom_cnt = ctm_inc(st_reg.dom_cnt);
                    if (st_reg.dom_cnt >= DOM_TO_TICKS) begin
                        st_next.wake_req   = 1'b0;
                        st_next.wake_armed = 1'b0;
                    end
                end
            end
            st_next.rxd = !st_next.wake_req;
        end else begin
            st_next.wake_armed = 1'b0;
            st_next.wake_req   = 1'b0;
            st_next.wake_cnt   = 12'h000;
            st_next.dom_cnt    = 12'h000;
            st_next.rxd        = !st_reg.bus_lvl;
        end

        // silent and standby never drive, whatever transmit does
        st_next.drive = (st_next.mode == ctm_pkg::CTM_NORMAL) && !st_reg.txd_lvl
                        && !st_next.txd_to;

        if (st_reg.wr_pend && st_reg.wr_addr == `CTM_OFS_FILT) begin
            st_next.filt = hwdata[11:0];
        end
        st_next.wr_pend = addr_ok && hwrite;
        st_next.wr_addr = haddr[7:0];
        st_next.rdata   = 32'h0000_0000;
        if (addr_ok && !hwrite && haddr[31:8] == 24'h00_0000) begin
            if (haddr[7:0] == `CTM_OFS_FILT) begin
                st_next.rdata[11:0] = st_reg.filt;
            end else if (haddr[7:0] == `CTM_OFS_STAT) begin
                st_next.rdata[`CTM_STAT_MODE_LSB +: 2] = st_reg.mode;
                st_next.rdata[`CTM_STAT_WAKE]          = st_reg.wake_req;
                st_next.rdata[`CTM_STAT_TXDTO]         = st_reg.txd_to;
                st_next.rdata[`CTM_STAT_RXD]           = st_reg.rxd;
                st_next.rdata[`CTM_STAT_DRIVE]         = st_reg.drive;
            end
        end
        if (haddr[31:8] != 24'h00_0000) begin
            st_next.wr_pend = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg          <= '0;
            st_reg.mode     <= ctm_pkg::CTM_STANDBY;
            st_reg.standby_select_sy  <= 3'h7;
            st_reg.sil_sy   <= 3'h7;
            st_reg.txd_sy   <= 3'h7;
            st_reg.standby_select_lvl <= 1'b1;
            st_reg.sil_lvl  <= 1'b1;
            st_reg.txd_lvl  <= 1'b1;
            st_reg.rxd      <= 1'b1;
            st_reg.filt     <= `CTM_FILT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata             = st_reg.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign rxd                = st_reg.rxd;
    assign drive_dominant     = st_reg.drive;
    assign transmitter_en     = (st_reg.mode == ctm_pkg::CTM_NORMAL);
    assign fast_comparator_en = (st_reg.mode != ctm_pkg::CTM_STANDBY);
    assign wake_comparator_en = (st_reg.mode == ctm_pkg::CTM_STANDBY);

    AST_STANDBY_SELECT_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.standby_select_lvl |=> st_reg.mode == ctm_pkg::CTM_STANDBY)
        else $error("standby select high did not give standby");
    AST_SILENT_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_reg.standby_select_lvl && !sil_eff) |=> st_reg.mode == ctm_pkg::CTM_SILENT)
        else $error("silent selection not taken");
    AST_NORMAL_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_reg.mode != ctm_pkg::CTM_NORMAL) ##1 (st_reg.mode == ctm_pkg::CTM_NORMAL)
        |-> $past(st_reg.txd_lvl) && !$past(st_reg.standby_select_lvl))
        else $error("normal mode entered with transmit low");
    AST_DRIVE_ONLY_NORMAL: assert property (@(posedge hclk) disable iff (!hresetn)
        drive_dominant |-> transmitter_en && !$past(st_reg.txd_lvl))
        else $error("bus driven outside normal mode or with transmit high");
    // a standby request in the same cycle hands rxd to the wake logic instead
    AST_RXD_FOLLOWS_BUS: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_reg.mode != ctm_pkg::CTM_STANDBY && !st_reg.standby_select_lvl)
        |=> rxd == !$past(st_reg.bus_lvl))
        else $error("receive output does not follow bus");
    AST_STANDBY_SELECT_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_reg.mode == ctm_pkg::CTM_STANDBY)
        |-> !drive_dominant && !transmitter_en && !fast_comparator_en)
        else $error("transmit path active in standby");
    AST_NORMAL_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_reg.mode == ctm_pkg::CTM_NORMAL && !st_reg.txd_lvl && !st_reg.txd_to
         && st_reg.txd_cnt < TXD_TO_TICKS && !st_reg.standby_select_lvl && sil_eff)
        |=> drive_dominant)
        else $error("transmit low not driven dominant in normal mode");
    AST_WAKE_FILTER: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_reg.standby_select_lvl && st_reg.wake_armed && st_reg.wake_lvl && st_reg.tick
         && st_reg.wake_cnt >= st_reg.filt && !st_reg.wake_req)
        |=> !rxd)
        else $error("filtered dominant bus gave no wake request");
    AST_DOM_TIMEOUT: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_reg.standby_select_lvl && st_reg.wake_req && st_reg.wake_lvl && st_reg.tick
         && st_reg.dom_cnt >= DOM_TO_TICKS)
        |=> rxd)
        else $error("dominant time-out did not release receive output");
    AST_NO_SILENT_VARIANT: assert property (@(posedge hclk) disable iff (!hresetn)
        !HAS_SILENT |-> st_reg.mode != ctm_pkg::CTM_SILENT)
        else $error("silent mode without silent pin");
    AST_WAKE_KEEPS_STANDBY: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_reg.wake_req && st_reg.standby_select_lvl) |=> st_reg.mode == ctm_pkg::CTM_STANDBY)
        else $error("wake request left standby");
    AST_WAKE_RXD_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_reg.wake_req && st_reg.standby_select_lvl) |-> !rxd)
        else $error("wake request not shown on receive output");
    AST_TXD_TIMEOUT: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.txd_to |=> !drive_dominant)
        else $error("driver still dominant after time-out");
endmodule : ctm_top

// *** ctm_ctrl_model.sv ***
module ctm_ctrl_model (
    input  wire logic       hclk,            // clock
    input  wire logic [1:0] mode_req,        // bit0 leave standby, bit1 silent
    input  wire logic       txd_req,         // wanted transmit level
    input  wire logic       wake_leave,      // leave standby on wake request
    input  wire logic       rxd,             // receive pin
    output logic            standby_select,  // mode pin
    output logic            silent_select_n, // mode pin
    output logic            txd              // transmit pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic woke = 1'b0;
    initial begin
        standby_select = 1'b1;
        silent_select_n = 1'b1;
        txd = 1'b1;
    end
    always @(posedge hclk) begin
        if (mode_req[0])
            woke <= 1'b0;
        else if (wake_leave && rxd === 1'b0)
            woke <= 1'b1;
        standby_select <= !mode_req[0] && !woke;
        // code 2 breaks the quiescent advice on purpose
        silent_select_n <= !mode_req[1];
        txd <= txd_req;
    end
endmodule : ctm_ctrl_model

// *** tb_can_transceiver_mode_control.sv ***
`include "ctm_params.svh"
module tb_can_transceiver_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, sb, sn, tx, rxd, drive_dominant;
    logic        transmitter_en, fast_comparator_en, wake_comparator_en;
    logic        bus_d = 1'b0;
    logic        ext_dom = 1'b0;
    logic [1:0]  mode_req = 2'h0;
    logic        txd_req = 1'b1;
    logic        wake_leave = 1'b0;
    logic [31:0] rd;
    int          fail_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          c0;
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        bus_d <= drive_dominant | ext_dom;
    end
    ctm_top #(.TXD_TO_TICKS(12'h004), .DOM_TO_TICKS(12'h004)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .standby_select(sb), .silent_select_n(sn),
        .txd(tx), .bus_dominant(bus_d), .wake_dominant(bus_d), .rxd(rxd),
        .drive_dominant(drive_dominant), .transmitter_en(transmitter_en),
        .fast_comparator_en(fast_comparator_en), .wake_comparator_en(wake_comparator_en));
    ctm_ctrl_model ctrl_u (.hclk(hclk), .mode_req(mode_req), .txd_req(txd_req),
        .wake_leave(wake_leave), .rxd(rxd), .standby_select(sb), .silent_select_n(sn),
        .txd(tx));
    task automatic print_verdict();
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        chk(hresp, 1'b0);
        if (n >= 100) begin fail_count++; print_verdict(); end
    endtask : ahb
    // sel: 0 rxd, 1 drive_dominant, 2 transmitter_en
    task automatic wait_for(input int sel, input logic v);
        logic s;
        for (int n = 0; n < 1000; n++) begin
            @(posedge hclk);
            s = (sel == 0) ? rxd : (sel == 1) ? drive_dominant : transmitter_en;
            if (s === v) return;
        end
        fail_count++;
        print_verdict();
    endtask : wait_for
    task automatic t_reset();
        chk({rxd, drive_dominant, wake_comparator_en}, 3'b101);
        ahb(1'b0, `CTM_OFS_STAT, 32'h0);
        chk(rd[1:0], ctm_pkg::CTM_STANDBY);
        ahb(1'b0, `CTM_OFS_FILT, 32'h0);
        chk(rd, `CTM_FILT_RST);
        ahb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h0000_0100, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset
    task automatic t_normal();
        txd_req <= 1'b0;
        mode_req <= 2'h1;
        repeat (20) @(posedge hclk);
        ahb(1'b0, `CTM_OFS_STAT, 32'h0);
        chk(rd[1:0], ctm_pkg::CTM_STANDBY);
        txd_req <= 1'b1;
        wait_for(2, 1'b1);
        chk({fast_comparator_en, wake_comparator_en, drive_dominant}, 3'b100);
        txd_req <= 1'b0;
        wait_for(1, 1'b1);
        wait_for(0, 1'b0);
        txd_req <= 1'b1;
        wait_for(1, 1'b0);
        wait_for(0, 1'b1);
    endtask : t_normal
    task automatic t_txd_to();
        txd_req <= 1'b0;
        wait_for(1, 1'b1);
        c0 = cyc;
        wait_for(1, 1'b0);
        chk((cyc - c0) inside {[120:260]}, 1'b1);
        ahb(1'b0, `CTM_OFS_STAT, 32'h0);
        chk(rd[`CTM_STAT_TXDTO], 1'b1);
        txd_req <= 1'b1;
        wait_for(0, 1'b1);
    endtask : t_txd_to
    task automatic t_silent();
        mode_req <= 2'h3;
        txd_req <= 1'b0;
        wait_for(2, 1'b0);
        repeat (20) @(posedge hclk);
        chk({drive_dominant, fast_comparator_en, rxd}, 3'b011);
        ext_dom <= 1'b1;
        wait_for(0, 1'b0);
        ext_dom <= 1'b0;
        wait_for(0, 1'b1);
        txd_req <= 1'b1;
    endtask : t_silent
    task automatic t_wake();
        ahb(1'b1, `CTM_OFS_FILT, 32'h2);
        mode_req <= 2'h2;
        repeat (20) @(posedge hclk);
        ahb(1'b0, `CTM_OFS_STAT, 32'h0);
        chk(rd[1:0], ctm_pkg::CTM_STANDBY);
        chk({transmitter_en, fast_comparator_en, wake_comparator_en}, 3'b001);
        ext_dom <= 1'b1;
        c0 = cyc;
        wait_for(0, 1'b0);
        chk((cyc - c0) inside {[80:200]}, 1'b1);
        ahb(1'b0, `CTM_OFS_STAT, 32'h0);
        chk(rd[2:0], 3'b100);
        wait_for(0, 1'b1);
        chk(transmitter_en, 1'b0);
        ext_dom <= 1'b0;
        wake_leave <= 1'b1;
        mode_req <= 2'h0;
        repeat (20) @(posedge hclk);
        ext_dom <= 1'b1;
        wait_for(2, 1'b1);
        ext_dom <= 1'b0;
    endtask : t_wake
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_normal();
        t_txd_to();
        t_silent();
        t_wake();
        print_verdict();
    end
endmodule : tb_can_transceiver_mode_control
